/* hdl/count_if.sv */
// Purpose: Carries control and count state between the top and one count unit.
// Assumes: Single clock domain.
// Notes: The unit modport owns the count bytes and overflow pulses.
`timescale 1ns/10ps
interface count_if;
  dlct_pkg::timer_mode_t mode;
  logic inc_low;
  logic inc_high;
  logic wr_low;
  logic wr_high;
  logic [7:0] wdata;
  logic [7:0] low;
  logic [7:0] high;
  logic ovf_low;
  logic ovf_high;
  modport unit (input mode, inc_low, inc_high, wr_low, wr_high, wdata,
                output low, high, ovf_low, ovf_high);
  modport ctrl (output mode, inc_low, inc_high, wr_low, wr_high, wdata,
                input low, high, ovf_low, ovf_high);
endinterface

/* hdl/count_unit.sv */
// Purpose: One timer's count bytes and overflow detection in all four modes.
// Assumes: Increment enables are single-cycle and already gated by run logic.
// Notes: In 13-bit mode the top three low bits keep whatever was written.
`timescale 1ns/10ps
module count_unit (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control and state.
  count_if.unit cif
);
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic next_ovf_low;
  logic next_ovf_high;
  logic [12:0] c13;
  logic [15:0] c16;

  // ========================================================================
  // Next count per mode; a software write to a byte wins over counting.
  always_comb begin
    next_low = cif.low;
    next_high = cif.high;
    next_ovf_low = 1'b0;
    next_ovf_high = 1'b0;
    c13 = {cif.high, cif.low[4:0]} + 13'd1;
    c16 = {cif.high, cif.low} + 16'd1;
    unique case (cif.mode)
      dlct_pkg::MODE_13BIT: if (cif.inc_low) begin
        next_low = {cif.low[7:5], c13[4:0]};
        next_high = c13[12:5];
        next_ovf_low = (c13 == 13'd0);
      end
      dlct_pkg::MODE_16BIT: if (cif.inc_low) begin
        next_low = c16[7:0];
        next_high = c16[15:8];
        next_ovf_low = (c16 == 16'd0);
      end
      dlct_pkg::MODE_RELOAD8: if (cif.inc_low) begin
        next_low = (cif.low == 8'hff) ? cif.high : cif.low + 8'd1;
        next_ovf_low = (cif.low == 8'hff);
      end
      dlct_pkg::MODE_SPLIT: begin
        if (cif.inc_low) begin
          next_low = cif.low + 8'd1;
          next_ovf_low = (cif.low == 8'hff);
        end
        if (cif.inc_high) begin
          next_high = cif.high + 8'd1;
          next_ovf_high = (cif.high == 8'hff);
        end
      end
    endcase
    if (cif.wr_low) begin
      next_low = cif.wdata;
    end
    if (cif.wr_high) begin
      next_high = cif.wdata;
    end
  end

  // Count bytes and overflow pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.low <= 8'h00;
      cif.high <= 8'h00;
      cif.ovf_low <= 1'b0;
      cif.ovf_high <= 1'b0;
    end else begin
      cif.low <= next_low;
      cif.high <= next_high;
      cif.ovf_low <= next_ovf_low;
      cif.ovf_high <= next_ovf_high;
    end
  end

  AST_WRAP13: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.mode == dlct_pkg::MODE_13BIT && cif.inc_low && !cif.wr_low && !cif.wr_high
     && cif.high == 8'hff && cif.low[4:0] == 5'h1f)
    |=> cif.ovf_low && cif.high == 8'h00 && cif.low[4:0] == 5'h00)
    else $error("13-bit wrap did not clear count and flag overflow");
  AST_RELOAD8: assert property (@(posedge pclk) disable iff (!presetn)
    (cif.mode == dlct_pkg::MODE_RELOAD8 && cif.inc_low && !cif.wr_low && cif.low == 8'hff)
    |=> cif.ovf_low && cif.low == $past(cif.high))
    else $error("8-bit reload did not take the high byte");
endmodule // count_unit

/* hdl/dlct_map.svh */
// Purpose: Offsets, field positions, reset values and divider counts of the counter/timer pair.
// Assumes: APB with 32-bit data; each register is one aligned word.
// Notes: Definitions only.
// How it works
// - Each timer offers 13-bit, 16-bit and 8-bit reload modes; only timer zero splits.
// - Each 16-bit count is read and written as a low and a high byte.
// - Both timers have separate mode fields, run bits and flags.
// - In timer function a timer counts the prescaled tick or every system clock.
// - Count select high counts falling edges of the event pin, else the chosen clock.
// - Events up to a quarter of the system clock rate are counted.
// - In 13-bit mode the high byte holds bits 12..5, low bits 4..0 hold the rest.
// - Wrapping from 0x1fff to zero sets the overflow flag.
// - A set flag with its enable bit raises that timer's interrupt request.
// - Counting needs the run bit and either gate disabled or gate pin high; timer one ignores its run bit and gate while timer zero splits.
// - Setting run never clears or reloads the count.
// - Timer one behaves like timer zero, using its own bits and pins.
// - Prescale codes 00, 01, 10 divide the system clock by 12, 4, 48.
// - Timer one overflows pace the serial baud rate.
// - Prescale code 11 divides the external oscillator clock by 8.
// - Clock select 0 takes the prescaled tick, 1 the system clock; ignored when counting.
// - Mode codes: 13-bit, 16-bit, 8-bit reload, split or inactive.
// - A flag stays set until software clears it or the interrupt is taken.
`ifndef DLCT_MAP_SVH
`define DLCT_MAP_SVH

// ==========================================================================
// Register byte addresses.
`define OFS_ZERO_LOW 12'h000
`define OFS_ZERO_HIGH 12'h004
`define OFS_ONE_LOW 12'h008
`define OFS_ONE_HIGH 12'h00c
`define OFS_CONTROL 12'h010
`define OFS_MODE 12'h014
`define OFS_CLOCK 12'h018
`define OFS_IRQ_ENABLE 12'h01c

// ==========================================================================
// Field positions.
`define CTL_ONE_FLAG 7
`define CTL_ONE_RUN 6
`define CTL_ZERO_FLAG 5
`define CTL_ZERO_RUN 4
`define MODE_ONE_GATE 7
`define MODE_ONE_COUNT 6
`define MODE_ONE_LSB 4
`define MODE_ZERO_GATE 3
`define MODE_ZERO_COUNT 2
`define MODE_ZERO_LSB 0
`define CLK_ONE_SEL 4
`define CLK_ZERO_SEL 3
`define CLK_PRESCALE_LSB 0
`define IRQ_ZERO_EN 0
`define IRQ_ONE_EN 1

// ==========================================================================
// Reset values and divider counts.
`define RESET_BYTE 8'h00
`define DIV_SYS_12 6'd12
`define DIV_SYS_4 6'd4
`define DIV_SYS_48 6'd48
`define DIV_EXT_8 6'd8

`endif

/* hdl/dlct_pkg.sv */
// Purpose: Types shared by the counter/timer modules.
// Assumes: Constants live in dlct_map.svh.
// Notes: Nothing here is imported; users write dlct_pkg::name.
package dlct_pkg;
  // ========================================================================
  // Mode field encoding.
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_t;
endpackage

/* hdl/dual_legacy_counter_timer.sv */
// Purpose: Two legacy counter/timers with APB registers, gate and event pins.
// Assumes: pclk at 100 MHz; pins are asynchronous to pclk.
// Notes: Every output is a flip-flop; APB answers with no wait states.
`timescale 1ns/10ps
`include "dlct_map.svh"
module dual_legacy_counter_timer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins.
  input wire logic event_pin_zero,
  input wire logic event_pin_one,
  input wire logic gate_pin_zero_n,
  input wire logic gate_pin_one_n,
  input wire logic external_osc_clock,
  // Interrupt acknowledge from the processor, one cycle each.
  input wire logic irq_ack_zero,
  input wire logic irq_ack_one,
  // Interrupt requests and baud pacing.
  output logic timer_zero_irq,
  output logic timer_one_irq,
  output logic baud_tick
);
  logic [7:0] timer_control_reg;
  logic [7:0] timer_mode_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] interrupt_enable_reg;
  logic timer_zero_overflow_flag;
  logic timer_one_overflow_flag;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] event_prev;
  logic ev_fall_zero;
  logic ev_fall_one;
  logic prescale_tick;
  logic run_zero;
  logic run_one;
  logic split;
  logic tick_zero;
  logic tick_one;
  logic wr_access;
  logic set_zero;
  logic set_one;
  logic wr_ctl;
  logic [7:0] wbyte;
  logic [7:0] read_mux;
  logic mapped;
  logic [1:0] run_bits;

  count_if zero_if ();
  count_if one_if ();

  // ========================================================================
  // Pin synchronisers: bit 0/1 events, bit 2/3 gates; edges read stage two.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
      event_prev <= 2'b00;
    end else begin
      pin_meta <= {gate_pin_one_n, gate_pin_zero_n, event_pin_one, event_pin_zero};
      pin_sync <= pin_meta;
      event_prev <= pin_sync[1:0];
    end
  end

  // One falling edge per transition; a level held two cycles is never missed.
  assign ev_fall_zero = event_prev[0] & ~pin_sync[0];
  assign ev_fall_one = event_prev[1] & ~pin_sync[1];

  prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .prescale_select(clock_control_reg[`CLK_PRESCALE_LSB +: 2]),
    .external_osc_clock(external_osc_clock),
    .prescale_tick(prescale_tick)
  );

  // ========================================================================
  // Count enables. Timer one loses its pin and flag while timer zero splits.
  assign split = (timer_mode_reg[`MODE_ZERO_LSB +: 2] == 2'b11);
  assign tick_zero = timer_mode_reg[`MODE_ZERO_COUNT] ? ev_fall_zero :
                     (clock_control_reg[`CLK_ZERO_SEL] ? 1'b1 : prescale_tick);
  assign tick_one = (timer_mode_reg[`MODE_ONE_COUNT] && !split) ? ev_fall_one :
                    (clock_control_reg[`CLK_ONE_SEL] ? 1'b1 : prescale_tick);
  assign run_zero = timer_control_reg[`CTL_ZERO_RUN] &&
                    (!timer_mode_reg[`MODE_ZERO_GATE] || pin_sync[2]);
  assign run_one = split ? (timer_mode_reg[`MODE_ONE_LSB +: 2] != 2'b11) :
                   (timer_control_reg[`CTL_ONE_RUN] && timer_mode_reg[`MODE_ONE_LSB +: 2] != 2'b11
                    && (!timer_mode_reg[`MODE_ONE_GATE] || pin_sync[3]));

  // Run bits only gate counting; nothing reloads the count on a rising run.
  assign zero_if.mode = dlct_pkg::timer_mode_t'(timer_mode_reg[`MODE_ZERO_LSB +: 2]);
  assign zero_if.inc_low = run_zero && tick_zero;
  assign zero_if.inc_high = split && timer_control_reg[`CTL_ONE_RUN] &&
                            (clock_control_reg[`CLK_ZERO_SEL] ? 1'b1 : prescale_tick);
  assign one_if.mode = (timer_mode_reg[`MODE_ONE_LSB +: 2] == 2'b11) ?
                       dlct_pkg::MODE_13BIT :
                       dlct_pkg::timer_mode_t'(timer_mode_reg[`MODE_ONE_LSB +: 2]);
  assign one_if.inc_low = run_one && tick_one;
  assign one_if.inc_high = 1'b0;

  count_unit u_zero (
    .pclk(pclk),
    .presetn(presetn),
    .cif(zero_if)
  );

  count_unit u_one (
    .pclk(pclk),
    .presetn(presetn),
    .cif(one_if)
  );

  // ========================================================================
  // APB decode. A write lands in the access phase, which is also the answer.
  assign wr_access = psel && penable && pwrite && pready;
  assign wbyte = pwdata[7:0];
  assign wr_ctl = wr_access && paddr == `OFS_CONTROL;
  assign zero_if.wdata = wbyte;
  assign one_if.wdata = wbyte;
  assign zero_if.wr_low = wr_access && paddr == `OFS_ZERO_LOW;
  assign zero_if.wr_high = wr_access && paddr == `OFS_ZERO_HIGH;
  assign one_if.wr_low = wr_access && paddr == `OFS_ONE_LOW;
  assign one_if.wr_high = wr_access && paddr == `OFS_ONE_HIGH;
  assign mapped = (paddr[11:5] == 7'd0) && (paddr[1:0] == 2'b00);

  // Readback; the undefined 13-bit low bits simply show their stored value.
  always_comb begin
    unique case (paddr)
      `OFS_ZERO_LOW: read_mux = zero_if.low;
      `OFS_ZERO_HIGH: read_mux = zero_if.high;
      `OFS_ONE_LOW: read_mux = one_if.low;
      `OFS_ONE_HIGH: read_mux = one_if.high;
      `OFS_CONTROL: read_mux = timer_control_reg;
      `OFS_MODE: read_mux = timer_mode_reg;
      `OFS_CLOCK: read_mux = clock_control_reg;
      `OFS_IRQ_ENABLE: read_mux = interrupt_enable_reg;
      default: read_mux = 8'h00;
    endcase
  end

  // Bus answer registered in the setup phase so pready is high in access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, read_mux};
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_reg <= `RESET_BYTE;
      clock_control_reg <= `RESET_BYTE;
      interrupt_enable_reg <= `RESET_BYTE;
    end else begin
      if (wr_access && paddr == `OFS_MODE) begin
        timer_mode_reg <= wbyte;
      end
      if (wr_access && paddr == `OFS_CLOCK) begin
        clock_control_reg <= wbyte & 8'h1b;
      end
      if (wr_access && paddr == `OFS_IRQ_ENABLE) begin
        interrupt_enable_reg <= wbyte & 8'h03;
      end
    end
  end

  // ========================================================================
  // Overflow flags: a hardware set in the clearing cycle wins.
  assign set_zero = zero_if.ovf_low;
  assign set_one = split ? zero_if.ovf_high : one_if.ovf_low;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_zero_overflow_flag <= 1'b0;
      timer_one_overflow_flag <= 1'b0;
    end else begin
      timer_zero_overflow_flag <= set_zero || (!irq_ack_zero &&
        (wr_ctl ? wbyte[`CTL_ZERO_FLAG] : timer_zero_overflow_flag));
      timer_one_overflow_flag <= set_one || (!irq_ack_one &&
        (wr_ctl ? wbyte[`CTL_ONE_FLAG] : timer_one_overflow_flag));
    end
  end

  // Run bits: bit 0 is timer zero, bit 1 is timer one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_bits <= 2'b00;
    end else if (wr_ctl) begin
      run_bits <= {wbyte[`CTL_ONE_RUN], wbyte[`CTL_ZERO_RUN]};
    end
  end

  // The control register has one driver, so run bits and flags never fight.
  always_comb begin
    timer_control_reg = `RESET_BYTE;
    timer_control_reg[`CTL_ZERO_RUN] = run_bits[0];
    timer_control_reg[`CTL_ONE_RUN] = run_bits[1];
    timer_control_reg[`CTL_ZERO_FLAG] = timer_zero_overflow_flag;
    timer_control_reg[`CTL_ONE_FLAG] = timer_one_overflow_flag;
  end

  // Interrupt requests and the baud tick, which follows timer one in every mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_zero_irq <= 1'b0;
      timer_one_irq <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      timer_zero_irq <= timer_zero_overflow_flag && interrupt_enable_reg[`IRQ_ZERO_EN];
      timer_one_irq <= timer_one_overflow_flag && interrupt_enable_reg[`IRQ_ONE_EN];
      baud_tick <= one_if.ovf_low;
    end
  end

  // ========================================================================
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    zero_if.ovf_low |=> timer_zero_overflow_flag)
    else $error("overflow did not set timer zero flag");
  AST_SPLIT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (split && zero_if.ovf_high) |=> timer_one_overflow_flag)
    else $error("split high byte overflow did not set timer one flag");
  AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_zero_overflow_flag && !wr_ctl && !irq_ack_zero) |=> timer_zero_overflow_flag)
    else $error("timer zero flag dropped without a clear");
  AST_IRQ_RAISE: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_one_overflow_flag && interrupt_enable_reg[`IRQ_ONE_EN]) |=> timer_one_irq)
    else $error("timer one request not raised");
  AST_HOLD_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
    (!timer_control_reg[`CTL_ZERO_RUN] && !zero_if.wr_low && !zero_if.wr_high && !split)
    |=> $stable(zero_if.low) && $stable(zero_if.high))
    else $error("stopped timer zero changed its count");
  AST_GATE_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_mode_reg[`MODE_ZERO_GATE] && !pin_sync[2]) |-> !zero_if.inc_low)
    else $error("timer zero counted with its gate pin low");
  AST_EVENT_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_mode_reg[`MODE_ZERO_COUNT] && zero_if.inc_low) |-> $past(pin_sync[0]) && !pin_sync[0])
    else $error("event count without a falling edge");
  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not given in the access phase");
endmodule // dual_legacy_counter_timer

/* hdl/prescaler.sv */
// Purpose: Makes the one-cycle prescaled tick shared by both timers.
// Assumes: external_osc_clock is asynchronous and much slower than pclk.
// Notes: Changing the code mid-period restarts cleanly at the next tick.
`timescale 1ns/10ps
`include "dlct_map.svh"
module prescaler (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control and clock sources.
  input wire logic [1:0] prescale_select,
  input wire logic external_osc_clock,
  // Tick.
  output logic prescale_tick
);
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic [5:0] div_count;
  logic step;
  logic [5:0] limit;

  // Divide length for each prescale code.
  function automatic logic [5:0] div_limit(input logic [1:0] sel);
    unique case (sel)
      2'b00: div_limit = `DIV_SYS_12;
      2'b01: div_limit = `DIV_SYS_4;
      2'b10: div_limit = `DIV_SYS_48;
      2'b11: div_limit = `DIV_EXT_8;
    endcase
  endfunction

  // ========================================================================
  // Oscillator synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_meta <= external_osc_clock;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // External code steps on oscillator rising edges, others on every cycle.
  assign limit = div_limit(prescale_select);
  assign step = (prescale_select == 2'b11) ? (osc_sync & ~osc_prev) : 1'b1;

  // ========================================================================
  // Divider; >= guards against a count left high by a shorter new code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 6'd0;
      prescale_tick <= 1'b0;
    end else begin
      prescale_tick <= 1'b0;
      if (step) begin
        if (div_count >= limit - 6'd1) begin
          div_count <= 6'd0;
          prescale_tick <= 1'b1;
        end else begin
          div_count <= div_count + 6'd1;
        end
      end
    end
  end

  AST_DIV4_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    (prescale_tick && prescale_select == 2'b01 ##1 prescale_select == 2'b01 [*4])
    |-> prescale_tick && $past(!prescale_tick))
    else $error("divide by 4 tick period wrong");
endmodule // prescaler

/* tb/dual_legacy_counter_timer_tb.sv */
// Purpose: Self-checking bench for the counter/timer pair.
// Assumes: APB answers within a few cycles; pins are modelled by pin_model.
// Notes: Reads and baud periods are checked from queues by a monitor.
`timescale 1ns/10ps
`include "dlct_map.svh"
module dual_legacy_counter_timer_tb;
  logic pclk, presetn, psel, penable, pwrite, ext_osc, ack0, ack1;
  logic pready, pslverr, irq0, irq1, baud_tick, ev0, ev1, g0, g1;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [32:0] exp_q[$];
  logic [32:0] mask_q[$];
  int per_q[$];
  int err_total, n_checks, since, seed, k;

  dual_legacy_counter_timer dual_legacy_counter_timer_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_pin_zero(ev0),
    .event_pin_one(ev1), .gate_pin_zero_n(g0), .gate_pin_one_n(g1),
    .external_osc_clock(ext_osc), .irq_ack_zero(ack0), .irq_ack_one(ack1),
    .timer_zero_irq(irq0), .timer_one_irq(irq1), .baud_tick(baud_tick));
  pin_model pin_model_i (.pclk(pclk), .event_pin_zero(ev0), .event_pin_one(ev1),
    .gate_pin_zero_n(g0), .gate_pin_one_n(g1));

  // ==========================================================================
  // Clocks; the slow oscillator period is eight pclk periods and it toggles on falling pclk edges.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    ext_osc = 1'b0;
    forever #40 ext_osc = ~ext_osc;
  end

  task automatic check_word(string what, logic [32:0] e, logic [32:0] s);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic check_period(int e, int s);
    n_checks++;
    if (s != e) begin
      err_total++;
      $display("wrong value baud period expected %0d seen %0d", e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // Monitor: completed reads and baud intervals take the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check_word("read", exp_q.pop_front(), {pslverr, prdata} & mask_q.pop_front());
    end
    since = since + 1;
    if (baud_tick === 1'b1) begin
      if (per_q.size() > 0) check_period(per_q.pop_front(), since);
      since = 0;
    end
  end

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] m, input logic [32:0] e);
    mask_q.push_back(m);
    exp_q.push_back(e & m);
    apb(1'b0, a, 8'h0);
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    int t, c, n;
    logic [13:0] sum;
    logic [12:0] st;
    logic [3:0] cs;
    logic [32:0] ctl;
    logic [11:0] lo;
    int per[5];
    per = '{217, 24, 8, 96, 128};
    seed = 32'hae6d;
    {psel, penable, pwrite, ack0, ack1, presetn} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 9; a++) rd(12'(a * 4), 33'h1ffffffff, a == 8 ? 33'h100000000 : 33'h0);
    $display("reset values done");
    // Cases are run, gate enable, gate pin, expected counting.
    for (t = 0; t < 2; t++) for (c = 0; c < 4; c++) begin
      cs = 4'(16'hfc92 >> (4 * c));
      st = 13'($random(seed));
      st[4:2] = 3'b111;
      if (c[0]) st[12:5] = 8'hff;
      n = 1 + {$random(seed)} % 6;
      sum = 14'(st + (cs[0] ? n : 0));
      lo = `OFS_ZERO_LOW + 12'(8 * t);
      ctl = (33'(cs[3]) << (4 + 2 * t)) | (33'(sum[13]) << (5 + 2 * t));
      apb(1'b1, `OFS_CONTROL, 8'h0);
      apb(1'b1, lo, {3'b101, st[4:0]});
      apb(1'b1, lo + 12'h004, st[12:5]);
      apb(1'b1, `OFS_MODE, 8'({cs[2], 3'b100}) << (4 * t));
      apb(1'b1, `OFS_IRQ_ENABLE, 8'(1 << t));
      pin_model_i.gate(t, cs[1]);
      apb(1'b1, `OFS_CONTROL, 8'(cs[3]) << (4 + 2 * t));
      pin_model_i.events(t, n);
      repeat (6) @(posedge pclk);
      rd(lo, 33'h10000001f, {28'h0, sum[4:0]});
      rd(lo + 12'h004, 33'h1000000ff, {25'h0, sum[12:5]});
      rd(`OFS_CONTROL, 33'h1000000ff, ctl);
      check_word("irq", {32'h0, sum[13]}, {32'h0, t ? irq1 : irq0});
      if (sum[13]) begin
        if (t) ack1 <= 1'b1;
        else ack0 <= 1'b1;
        @(posedge pclk);
        {ack0, ack1} <= 2'b00;
        repeat (2) @(posedge pclk);
        rd(`OFS_CONTROL, 33'h1000000ff, 33'(cs[3]) << (4 + 2 * t));
        check_word("irq", 33'h0, {32'h0, t ? irq1 : irq0});
      end
      $display("gate case %0d timer %0d done", c, t);
    end
    // Timer zero counts pin events in 16-bit mode, then as the split low byte.
    for (c = 0; c < 2; c++) begin
      apb(1'b1, `OFS_CONTROL, 8'h0);
      apb(1'b1, `OFS_ZERO_LOW, 8'hfe + 8'(c));
      apb(1'b1, `OFS_ZERO_HIGH, 8'hff);
      apb(1'b1, `OFS_MODE, c ? 8'h07 : 8'h05);
      apb(1'b1, `OFS_CLOCK, 8'h08);
      apb(1'b1, `OFS_CONTROL, c ? 8'h50 : 8'h10);
      pin_model_i.events(0, 3 - c);
      repeat (6) @(posedge pclk);
      rd(`OFS_ZERO_LOW, 33'h1000000ff, 33'h1);
      if (c == 0) rd(`OFS_ZERO_HIGH, 33'h1000000ff, 33'h0);
      rd(`OFS_CONTROL, 33'h1000000ff, c ? 33'hf0 : 33'h30);
      $display("timer zero mode %0d done", c ? 3 : 1);
    end
    // Timer one in reload mode paces baud ticks for each clock source.
    for (c = 0; c < 5; c++) begin
      apb(1'b1, `OFS_CONTROL, 8'h0);
      apb(1'b1, `OFS_MODE, 8'h20);
      apb(1'b1, `OFS_CLOCK, c == 0 ? 8'h10 : 8'(c - 1));
      apb(1'b1, `OFS_ONE_LOW, c == 0 ? 8'h27 : 8'hfe);
      apb(1'b1, `OFS_ONE_HIGH, c == 0 ? 8'h27 : 8'hfe);
      apb(1'b1, `OFS_CONTROL, 8'h40);
      k = 0;
      do @(posedge pclk); while (baud_tick !== 1'b1 && ++k < 1000);
      @(posedge pclk);
      per_q.push_back(per[c]);
      do @(posedge pclk); while (per_q.size() > 0 && ++k < 2000);
      if (k >= 2000) err_total++;
      $display("baud source %0d done", c);
    end
    give_verdict;
  end
endmodule // dual_legacy_counter_timer_tb

/* tb/pin_model.sv */
// Purpose: Far-side model that drives the event and gate pins of both timers.
// Assumes: Its tasks are called just after a rising pclk edge.
// Notes: Pins idle high; a gate pin is high when counting is allowed.
`timescale 1ns/10ps
module pin_model (
  // Clock.
  input wire logic pclk,
  // Pins.
  output logic event_pin_zero,
  output logic event_pin_one,
  output logic gate_pin_zero_n,
  output logic gate_pin_one_n
);
  // ==========================================================================
  // Idle levels.
  initial begin
    event_pin_zero = 1'b1;
    event_pin_one = 1'b1;
    gate_pin_zero_n = 1'b1;
    gate_pin_one_n = 1'b1;
  end

  // Three cycles per level leaves margin over the two-cycle minimum hold.
  task automatic events(input int t, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      if (t == 0) event_pin_zero <= i[0];
      else event_pin_one <= i[0];
      repeat (3) @(posedge pclk);
    end
  endtask

  // The gate level is let settle through the synchroniser before use.
  task automatic gate(input int t, input logic v);
    if (t == 0) gate_pin_zero_n <= v;
    else gate_pin_one_n <= v;
    repeat (4) @(posedge pclk);
  endtask
endmodule // pin_model
